//--- logic/lec_regs.svh
`ifndef LEC_REGS_SVH
`define LEC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LEC_ADDR_LANE6_HOLD 12'h48e
`define LEC_ADDR_LANE7_HOLD 12'h48f
`define LEC_ADDR_LANE0_STAT 12'h490
`define LEC_ADDR_LANE1_STAT 12'h491

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define LEC_BIT_UNEXP_CTRL 2
`define LEC_BIT_TABLE_MISS 1
`define LEC_BIT_DISPARITY 0
`define LEC_BIT_LANE_ACTIVE 3
`define LEC_HOLD_RESET 3'h7
`define LEC_STAT_RESET 8'h00
`define LEC_CNT_TERMINAL 8'hff
`define LEC_NUM_LANES 8
`define LEC_NUM_CNT 3

`endif

//--- logic/lec_pkg.sv
package lec_pkg;
    typedef logic [7:0] lec_cnt_t;
    // one error strobe per counter type, bit order as the counters
    typedef struct packed {
        logic unexpected_control_char_err;
        logic code_table_miss_err;
        logic disparity_err;
    } lec_err_s;
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } lec_reg_req_s;
endpackage

//--- logic/lec_lane_err_counters.sv
`timescale 1ns/1ps
`include "lec_regs.svh"

// Contract
// RQ1 - three counters per lane: bit2 control char, bit1 table miss, bit0 disparity
// RQ2 - hold bit set: counter stops at 0xff until user clears it
// RQ3 - hold bit clear: counter wraps to zero and keeps counting
// RQ4 - three-bit hold field per lane, resets to all ones
// RQ5 - software writes hold fields only while the lane decoder is in soft reset
// RQ6 - read-only three-bit terminal-reached flags, same bit order as counters
// RQ7 - status bit 3 reads 0 in soft reset, 1 when lane enabled; resets 0
// RQ8 - counters add one per error and clear on user counter reset
module lec_lane_err_counters
    import lec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire lec_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire lec_err_s [7:0] lane_err,
    input wire logic [7:0] lane_decoder_soft_rst,
    input wire logic [7:0] cnt_clear,
    output lec_cnt_t [7:0][2:0] err_count,
    output logic [7:0][2:0] hold_enable
);

    // ----------------------------------------
    // address and field decode helpers
    // ----------------------------------------
    // one decode serves write and read, so the two paths cannot drift apart
    // helpers read no state, so they fold into the muxes
    function automatic logic is_hold6(input logic [11:0] addr);
        return addr == `LEC_ADDR_LANE6_HOLD;
    endfunction

    function automatic logic is_hold7(input logic [11:0] addr);
        return addr == `LEC_ADDR_LANE7_HOLD;
    endfunction

    // reserved upper bits always read zero
    function automatic logic [7:0] hold_byte(input logic [2:0] hold);
        return {5'h00, hold};
    endfunction

    // lane active in bit 3, terminal flags below it in counter order
    function automatic logic [7:0] stat_byte(input logic active, input logic [2:0] flags);
        return {4'h0, active, flags};
    endfunction

    // ----------------------------------------
    // hold enable fields
    // ----------------------------------------
    // only lanes 6 and 7 are writable here; other lanes keep reset value
    // lanes 0 to 5 keep all ones, so their counters always saturate
    logic [7:0][2:0] hold_ff;
    logic [7:0][2:0] nxt_hold;

    // hold writes belong in soft reset; keeping that is software's duty
    // no interlock here: a write in normal operation still lands at once
    always_comb begin
        nxt_hold = hold_ff;
        if (reg_req.wr && is_hold6(reg_req.addr)) begin
            nxt_hold[6] = reg_req.wdata[2:0]; // RQ4
        end else if (reg_req.wr && is_hold7(reg_req.addr)) begin
            nxt_hold[7] = reg_req.wdata[2:0]; // RQ4
        end
    end

    // every lane comes out of reset saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= {`LEC_NUM_LANES{`LEC_HOLD_RESET}}; // RQ4
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    assign hold_enable = hold_ff;

    // ----------------------------------------
    // synchronisers for lane control pins
    // ----------------------------------------
    // pins are levels; a pulse shorter than one clock may be missed
    logic [7:0] srst_meta_ff;
    logic [7:0] srst_sync_ff;
    logic [7:0] clr_meta_ff;
    logic [7:0] clr_sync_ff;
    logic [7:0] nxt_srst_meta;
    logic [7:0] nxt_srst_sync;
    logic [7:0] nxt_clr_meta;
    logic [7:0] nxt_clr_sync;
    logic [7:0] active_ff;
    logic [7:0] nxt_active;

    // two stages per pin; only the second stage feeds any logic
    always_comb begin
        nxt_srst_meta = lane_decoder_soft_rst;
        nxt_srst_sync = srst_meta_ff;
        nxt_clr_meta = cnt_clear;
        nxt_clr_sync = clr_meta_ff;
    end

    // soft reset resets high so lanes start held, as the status bit says
    // clear resets low so counting starts as soon as the chip reset lifts
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srst_meta_ff <= 8'hff;
            srst_sync_ff <= 8'hff;
            clr_meta_ff <= 8'h00;
            clr_sync_ff <= 8'h00;
        end else begin
            srst_meta_ff <= nxt_srst_meta;
            srst_sync_ff <= nxt_srst_sync;
            clr_meta_ff <= nxt_clr_meta;
            clr_sync_ff <= nxt_clr_sync;
        end
    end

    // lane active is the inverse of soft reset
    // pin to status bit takes three edges: two sync stages and this flop
    always_comb begin
        nxt_active = ~srst_sync_ff; // RQ7
    end

    // status bit reads held until the synchronised pin says otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_ff <= 8'h00; // RQ7
        end else begin
            active_ff <= nxt_active;
        end
    end

    // ----------------------------------------
    // error counters
    // ----------------------------------------
    // err strobes come from the same clock domain, no sync
    // a lane's counters clear together; there is no per-counter clear
    lec_cnt_t [7:0][2:0] cnt_ff;
    lec_cnt_t [7:0][2:0] nxt_cnt;
    logic [7:0][2:0] tcr_ff;
    logic [7:0][2:0] nxt_tcr;

    // one counter cell per lane and error type
    genvar gl;
    genvar gc;
    generate
        for (gl = 0; gl < `LEC_NUM_LANES; gl++) begin : g_lane
            for (gc = 0; gc < `LEC_NUM_CNT; gc++) begin : g_cnt
                // clear wins over a coincident error; count and flag move together
                // a flag once set survives a wrap; only the clear drops it
                always_comb begin
                    nxt_cnt[gl][gc] = cnt_ff[gl][gc];
                    nxt_tcr[gl][gc] = tcr_ff[gl][gc];
                    if (clr_sync_ff[gl]) begin
                        nxt_cnt[gl][gc] = 8'h00; // RQ8
                        nxt_tcr[gl][gc] = 1'b0;
                    end else if (lane_err[gl][gc]) begin // RQ1
                        if (cnt_ff[gl][gc] == `LEC_CNT_TERMINAL && hold_ff[gl][gc]) begin
                            nxt_cnt[gl][gc] = cnt_ff[gl][gc]; // RQ2
                        end else begin
                            // wraps 0xff -> 0x00 when not holding
                            nxt_cnt[gl][gc] = cnt_ff[gl][gc] + 8'h01; // RQ3 RQ8
                        end
                    end
                    // flag sticks until clear, even after a wrap
                    if (nxt_cnt[gl][gc] == `LEC_CNT_TERMINAL) begin
                        nxt_tcr[gl][gc] = 1'b1; // RQ6
                    end
                end

                // counter and flag flops
                always_ff @(posedge clk_sys or negedge rst_n) begin
                    if (!rst_n) begin
                        cnt_ff[gl][gc] <= 8'h00;
                        tcr_ff[gl][gc] <= 1'b0;
                    end else begin
                        cnt_ff[gl][gc] <= nxt_cnt[gl][gc];
                        tcr_ff[gl][gc] <= nxt_tcr[gl][gc];
                    end
                end
            end
        end
    endgenerate

    assign err_count = cnt_ff;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // only lanes 0 and 1 carry a status register in this map
    // unmapped addresses read zero, so a stray read is harmless
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // registered read, data valid the cycle after the address
    // the address is decoded every cycle, so data tracks a held address
    always_comb begin
        if (is_hold6(reg_req.addr)) begin
            nxt_rdata = hold_byte(hold_ff[6]);
        end else if (is_hold7(reg_req.addr)) begin
            nxt_rdata = hold_byte(hold_ff[7]);
        end else if (reg_req.addr == `LEC_ADDR_LANE0_STAT) begin
            nxt_rdata = stat_byte(active_ff[0], tcr_ff[0]); // RQ6 RQ7
        end else if (reg_req.addr == `LEC_ADDR_LANE1_STAT) begin
            nxt_rdata = stat_byte(active_ff[1], tcr_ff[1]); // RQ6 RQ7
        end else begin
            nxt_rdata = `LEC_STAT_RESET;
        end
    end

    // a flop on the bus side, not a mux of live counters
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= `LEC_STAT_RESET;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

//--- verif/lec_err_monitor.sv
`timescale 1ns/1ps
module lec_err_monitor
    import lec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire lec_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire lec_err_s [7:0] lane_err,
    input wire logic [7:0] lane_decoder_soft_rst,
    input wire logic [7:0] cnt_clear,
    input wire lec_cnt_t [7:0][2:0] err_count,
    input wire logic [7:0][2:0] hold_enable
);
// -----
// checks
// -----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // five cycles covers the three-edge sync and register path
    sequence s_held; lane_decoder_soft_rst[0] [*5]; endsequence
    sequence s_run; !lane_decoder_soft_rst[0] [*5]; endsequence
    a_hold_write: assert property (reg_req.wr && reg_req.addr == 12'h48e |=>
        hold_enable[6] == $past(reg_req.wdata[2:0])) else $error("hold write");
    a_cnt_step: assert property (lane_err[0][2] && !$past(cnt_clear[0]) &&
        err_count[0][2] != 8'hff |=> err_count[0][2] == $past(err_count[0][2]) + 8'h01)
        else $error("count step");
    a_sat_hold: assert property (hold_enable[6][1] && err_count[6][1] == 8'hff &&
        !$past(cnt_clear[6]) |=> err_count[6][1] == 8'hff) else $error("saturate");
    a_cnt_wrap: assert property (!hold_enable[6][0] && err_count[6][0] == 8'hff &&
        lane_err[6][0] && !$past(cnt_clear[6]) |=> err_count[6][0] == 8'h00)
        else $error("wrap");
    a_flag_read: assert property (err_count[0][1] == 8'hff &&
        reg_req.addr == 12'h490 |=> reg_rdata[1]) else $error("flag");
    a_lane_held: assert property (s_held ##0 reg_req.addr == 12'h490 |=>
        !reg_rdata[3]) else $error("held bit");
    a_lane_run: assert property (s_run ##0 reg_req.addr == 12'h490 |=>
        reg_rdata[3]) else $error("run bit");
endmodule
bind lec_lane_err_counters lec_err_monitor lec_err_monitor_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .lane_err(lane_err),
    .lane_decoder_soft_rst(lane_decoder_soft_rst), .cnt_clear(cnt_clear),
    .err_count(err_count), .hold_enable(hold_enable));

//--- verif/lec_err_src.sv
`timescale 1ns/1ps
module lec_err_src
    import lec_pkg::*;
(
    input wire logic clk_sys,
    output lec_err_s [7:0] lane_err
);
    // back-to-back error pulses, one per cycle
    initial lane_err = '0;
    task automatic burst(input int l, input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            lane_err[l] <= m;
        end
        @(posedge clk_sys);
        lane_err[l] <= 3'h0;
    endtask
endmodule

//--- verif/lec_lane_err_counters_tb.sv
`timescale 1ns/1ps
module lec_lane_err_counters_tb;
    import lec_pkg::*;
    logic clk_sys, rst_n;
    lec_reg_req_s reg_req;
    logic [7:0] reg_rdata, soft_rst, cnt_clear;
    lec_err_s [7:0] lane_err;
    lec_cnt_t [7:0][2:0] cnt;
    logic [7:0][2:0] hold;
    int n_fail = 0;
    int tests_run = 0;
    lec_lane_err_counters lec_lane_err_counters_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .lane_err(lane_err),
        .lane_decoder_soft_rst(soft_rst), .cnt_clear(cnt_clear),
        .err_count(cnt), .hold_enable(hold));
    lec_err_src lec_err_src_i (.clk_sys(clk_sys), .lane_err(lane_err));
// -----
// tasks
// -----
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys) reg_req <= '{1'b1, a, d};
        @(posedge clk_sys) reg_req.wr <= 1'b0;
    endtask
    // read data is registered, so look one edge later
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys) reg_req.addr <= a;
        @(posedge clk_sys) #1 chk("rdata", e, reg_rdata);
    endtask
    task report_and_stop;
        $display("checks %0d wrong %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // whole run is about 600 cycles
    initial begin
        #50000 n_fail++;
        report_and_stop();
    end
    initial begin
        {rst_n, reg_req, cnt_clear} <= '0;
        soft_rst <= 8'hff;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(12'h48f, 8'h07);
        rd(12'h490, 8'h00);
        rd(12'h400, 8'h00);
        wr(12'h48e, 8'hfe);
        rd(12'h48e, 8'h06);
        wr(12'h48f, 8'h00);
        #1 chk("hold7", 8'h00, {5'h00, hold[7]});
        @(posedge clk_sys) soft_rst <= 8'h00;
        repeat (4) @(posedge clk_sys);
        rd(12'h491, 8'h08);
        $display("regs done");
        lec_err_src_i.burst(0, 3'b100, 3);
        lec_err_src_i.burst(0, 3'b001, 1);
        @(posedge clk_sys) #1 chk("ctl", 8'h03, cnt[0][2]);
        chk("tbl", 8'h00, cnt[0][1]);
        chk("dsp", 8'h01, cnt[0][0]);
        lec_err_src_i.burst(0, 3'b010, 300);
        @(posedge clk_sys) #1 chk("sat", 8'hff, cnt[0][1]);
        rd(12'h490, 8'h0a);
        lec_err_src_i.burst(6, 3'b011, 257);
        @(posedge clk_sys) #1 chk("wrap", 8'h01, cnt[6][0]);
        chk("hold", 8'hff, cnt[6][1]);
        $display("count done");
        @(posedge clk_sys) cnt_clear <= 8'hff;
        repeat (4) @(posedge clk_sys);
        rd(12'h490, 8'h08);
        chk("clr", 8'h00, cnt[6][1]);
        @(posedge clk_sys) cnt_clear <= 8'h00;
        soft_rst <= 8'h02;
        repeat (4) @(posedge clk_sys);
        rd(12'h491, 8'h00);
        $display("clear done");
        report_and_stop();
    end
endmodule
